// ===== rtl/ddrsp_pkg.sv
/*
  shared constants of the two-word burst double-data-rate sram port:
  data widths, byte-lane layout and array size.
  assumes every file that needs them imports this package.
*/
package ddrsp_pkg;
  localparam int DATA_WIDTH = 36;
  localparam int LANE_WIDTH = 9;
  localparam int LANES = 4;
  localparam int NARROW_LANES = 2;
  localparam int NARROW_WIDTH = 18;
  localparam int ADDR_WIDTH = 20;
  localparam logic [LANES-1:0] LANES_ALL_OFF = 4'hf;
  localparam logic [LANES-1:0] NARROW_UPPER_OFF = 4'hc;
endpackage

// ===== rtl/ddrsp_lane_merge.sv
/*
  byte-lane merge: replaces each selected 9-bit lane of the stored word
  with the incoming lane, keeps deselected lanes.
  assumes active-low lane selects, one per 9-bit lane.
*/
`timescale 1ns/1ps
module ddrsp_lane_merge (
  input wire logic [ddrsp_pkg::DATA_WIDTH-1:0] stored_word,
  input wire logic [ddrsp_pkg::DATA_WIDTH-1:0] incoming_word,
  input wire logic [ddrsp_pkg::LANES-1:0] lane_write_n,
  output logic [ddrsp_pkg::DATA_WIDTH-1:0] merged_word
);
  import ddrsp_pkg::*;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      // lane 0 bits 8:0, lane 1 17:9, lane 2 26:18, lane 3 35:27
      merged_word[i*LANE_WIDTH +: LANE_WIDTH] = lane_write_n[i] ?
          stored_word[i*LANE_WIDTH +: LANE_WIDTH] :
          incoming_word[i*LANE_WIDTH +: LANE_WIDTH];
    end
  end
endmodule

// ===== rtl/ddrsp_port.sv
/*
  command and data port of a two-word burst double-data-rate sram with
  its storage array. clock pins arrive as one-cycle rise pulses already
  synchronous to clk; the data pins are split into in, out and enable.
  assumes the controller keeps the turnaround and strap rules itself.
*/
//
// Summary of operation
// - a write is taken when the strobe and read_not_write are low at a k rise, its words come at the next k rise and the k_n rise after.
// - a read is taken when the strobe is low and read_not_write high at a k rise; word one leaves on the c_n rise after the next k rise, word two on the c rise after that.
// - word one uses the latched address and word two that address with its lowest bit inverted.
// - write data is taken on both input-clock rises and read data launched on output-clock rises, or on input-clock rises in single-clock mode.
// - after reset the port is deselected with its data drivers off until a read is issued.
// - on the narrow variant lane 0 gates bits 8 to 0 and lane 1 bits 17 to 9, per word, and an unselected lane keeps its bits.
// - on the narrow variant a word with both lanes off writes nothing.
// - on the wide variant lanes 0 to 3 gate bits 8-0, 17-9, 26-18 and 35-27 per word, unselected lanes kept.
// - on the wide variant a word with all four lanes off writes nothing.
`timescale 1ns/1ps
module ddrsp_port #(
  parameter bit wide_variant = 1'b1,
  parameter int addr_width = ddrsp_pkg::ADDR_WIDTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic k_rise,
  input wire logic k_n_rise,
  input wire logic c_rise,
  input wire logic c_n_rise,
  input wire logic c_level,
  input wire logic c_n_level,
  input wire logic address_strobe_n,
  input wire logic read_not_write,
  input wire logic [addr_width-1:0] address,
  input wire logic [ddrsp_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic [ddrsp_pkg::DATA_WIDTH-1:0] dq_in,
  output logic [ddrsp_pkg::DATA_WIDTH-1:0] dq_out,
  output logic dq_oe,
  output logic single_clock
);
  import ddrsp_pkg::*;

  logic [DATA_WIDTH-1:0] array_mem [0:(1<<addr_width)-1];

  // command stage: taken at a k rise
  logic wr_cmd;
  logic rd_cmd;
  logic [addr_width-1:0] cmd_addr;
  // data stages
  logic wr_second;
  logic [addr_width-1:0] wr_addr;
  logic rd_ready;
  logic rd_second;
  logic [addr_width-1:0] rd_addr;

  logic out_pos;
  logic out_neg;
  logic wr_strobe;
  logic [addr_width-1:0] wr_target;
  logic [LANES-1:0] lanes_eff;
  logic [DATA_WIDTH-1:0] stored_word;
  logic [DATA_WIDTH-1:0] merged_word;

  function automatic logic [addr_width-1:0] burst_partner(input logic [addr_width-1:0] a);
    burst_partner = {a[addr_width-1:1], ~a[0]};
  endfunction

  // strap caught while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      single_clock <= c_level & c_n_level;
    end
  end

  assign out_pos = single_clock ? k_rise : c_rise;
  assign out_neg = single_clock ? k_n_rise : c_n_rise;

  // command capture; with no k rise nothing moves
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_cmd <= 1'b0;
      rd_cmd <= 1'b0;
    end else if (k_rise) begin
      wr_cmd <= ~address_strobe_n & ~read_not_write;
      rd_cmd <= ~address_strobe_n & read_not_write;
    end
  end

  // address only moves when a command is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_addr <= '0;
    end else if (k_rise && !address_strobe_n) begin
      cmd_addr <= address;
    end
  end

  // write data: word one at the next k rise, word two at the k_n rise after
  always_comb begin
    wr_strobe = 1'b0;
    wr_target = wr_addr;
    if (k_rise && wr_cmd) begin
      wr_strobe = 1'b1;
      wr_target = cmd_addr;
    end else if (k_n_rise && wr_second) begin
      wr_strobe = 1'b1;
      wr_target = burst_partner(wr_addr);
    end
  end

  // narrow variant never writes the upper two lanes
  assign lanes_eff = wide_variant ? byte_lane_write_n
                                  : (byte_lane_write_n | NARROW_UPPER_OFF);
  assign stored_word = array_mem[wr_target];

  ddrsp_lane_merge u_merge (
    .stored_word(stored_word),
    .incoming_word(dq_in),
    .lane_write_n(lanes_eff),
    .merged_word(merged_word)
  );

  // word two is owed until the k_n rise that follows the data k rise
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_second <= 1'b0;
    end else if (k_rise) begin
      wr_second <= wr_cmd;
    end else if (k_n_rise) begin
      wr_second <= 1'b0;
    end
  end

  // kept apart so a command taken at the data k rise cannot disturb word two
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_addr <= '0;
    end else if (k_rise && wr_cmd) begin
      wr_addr <= cmd_addr;
    end
  end

  // all lanes off: array untouched for that word
  always_ff @(posedge clk) begin
    if (!reset && wr_strobe && lanes_eff != LANES_ALL_OFF) begin
      array_mem[wr_target] <= merged_word;
    end
  end

  // read pipeline
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_ready <= 1'b0;
    end else if (k_rise && rd_cmd) begin
      rd_ready <= 1'b1;
    end else if (out_neg) begin
      rd_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_addr <= '0;
    end else if (k_rise && rd_cmd) begin
      rd_addr <= cmd_addr;
    end
  end

  // launch decode shared by the output registers
  logic launch_first;
  logic launch_second;
  logic drive_done;

  function automatic logic [DATA_WIDTH-1:0] read_view(input logic [DATA_WIDTH-1:0] word);
    // narrow variant shows zeros on the unused upper pins
    if (wide_variant) begin
      read_view = word;
    end else begin
      read_view = {{(DATA_WIDTH-NARROW_WIDTH){1'b0}}, word[NARROW_WIDTH-1:0]};
    end
  endfunction

  assign launch_first = out_neg && rd_ready;
  assign launch_second = !launch_first && out_pos && rd_second;
  // drivers stay on until the out_pos after the last word, so banks hand over cleanly
  assign drive_done = !launch_first && out_pos && !rd_second;

  always_ff @(posedge clk) begin
    if (reset) begin
      dq_oe <= 1'b0;
    end else if (launch_first) begin
      dq_oe <= 1'b1;
    end else if (drive_done) begin
      dq_oe <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dq_out <= '0;
    end else if (launch_first) begin
      dq_out <= read_view(array_mem[rd_addr]);
    end else if (launch_second) begin
      dq_out <= read_view(array_mem[burst_partner(rd_addr)]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_second <= 1'b0;
    end else if (launch_first) begin
      rd_second <= 1'b1;
    end else if (launch_second) begin
      rd_second <= 1'b0;
    end
  end
endmodule

// ===== tb/ddrsp_port_properties.sv
/* port pin assertions.
   assumes clock-pin pulses arrive on distinct cycles. */
`timescale 1ns/1ps
module ddrsp_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic k_rise,
  input wire logic k_n_rise,
  input wire logic c_rise,
  input wire logic c_n_rise,
  input wire logic c_level,
  input wire logic c_n_level,
  input wire logic address_strobe_n,
  input wire logic read_not_write,
  input wire logic [ddrsp_pkg::DATA_WIDTH-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic single_clock
);
  import ddrsp_pkg::*;
  logic [1:0] nk;
  wire any_edge = k_rise || k_n_rise || c_rise || c_n_rise;
  // k rises since the last read command
  always_ff @(posedge clk) begin
    if (reset || (k_rise && !address_strobe_n && read_not_write)) begin
      nk <= {reset, reset};
    end else if (k_rise && nk != 2'h3) begin
      nk <= nk + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_oe_launch: assert property ($rose(dq_oe) |-> $past(c_n_rise || k_n_rise))
    else $error("drive began off a falling pulse");
  chk_oe_release: assert property ($fell(dq_oe) |-> $past(c_rise || k_rise))
    else $error("drive ended off a rising pulse");
  chk_read_latency: assert property ($rose(dq_oe) |-> nk == 2'h1)
    else $error("read data at wrong k count");
  chk_oe_hold: assert property ($rose(dq_oe) |-> dq_oe [*2])
    else $error("burst drive too short");
  chk_clock_still: assert property (!$past(any_edge) && !$past(reset) |->
    $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved with clocks stopped");
  chk_data_edge: assert property (!$stable(dq_out) && !$past(reset) |->
    $past(single_clock ? k_rise || k_n_rise : c_rise || c_n_rise))
    else $error("data moved off its clock");
  chk_strap_take: assert property (disable iff (1'b0) reset |=>
    single_clock == $past(c_level && c_n_level))
    else $error("strap not captured");
  chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !dq_oe && dq_out == '0)
    else $error("outputs active after reset");
endmodule
bind ddrsp_port ddrsp_port_checker chk (.clk, .reset, .k_rise, .k_n_rise, .c_rise, .c_n_rise,
  .c_level, .c_n_level, .address_strobe_n, .read_not_write, .dq_out, .dq_oe, .single_clock);

// ===== tb/ddrsp_ctrl.sv
/* controller clock model: k, k_n, c_n, c rise pulses in turn.
   assumes the bench drives run and the command pins. */
`timescale 1ns/1ps
module ddrsp_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic [1:0] ph,
  output logic [3:0] rises
);
  always_ff @(posedge clk) begin
    if (reset) begin
      ph <= 2'h0;
    end else if (run) begin
      ph <= ph + 2'h1;
    end
  end
  // stopped clocks give no pulses
  assign rises = run ? 4'h1 << ph : 4'h0;
endmodule

// ===== tb/tb.sv
/* bench for the wide port with a 6-bit address.
   assumes the controller model makes the clock-pin pulses. */
`timescale 1ns/1ps
module tb;
  import ddrsp_pkg::*;
  logic clk = 1'h0, reset = 1'h1, run = 1'h0, strobe_n = 1'h1, rnw = 1'h0, oe, single;
  logic strap = 1'h0;
  logic [5:0] addr = 6'h0;
  logic [3:0] rises, lanes = 4'hf;
  logic [DATA_WIDTH-1:0] din = '0, dout;
  logic [DATA_WIDTH-1:0] ref_mem [64];
  logic [1:0] ph;
  int mismatches = 0, n_checks = 0;
  always #2 clk = ~clk;
  ddrsp_ctrl ctrl (.clk, .reset, .run, .ph, .rises);
  ddrsp_port #(.addr_width(6)) dut (.clk, .reset, .k_rise(rises[0]), .k_n_rise(rises[1]),
    .c_n_rise(rises[2]), .c_rise(rises[3]), .c_level(strap), .c_n_level(strap),
    .address_strobe_n(strobe_n), .read_not_write(rnw), .address(addr),
    .byte_lane_write_n(lanes), .dq_in(din), .dq_out(dout), .dq_oe(oe), .single_clock(single));
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [DATA_WIDTH:0] got, input logic [DATA_WIDTH:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // returns at the edge that opens a cycle of phase p
  task automatic at(input logic [1:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ph != p - 2'h1 && n < 8);
    if (ph != p - 2'h1) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      summarize();
    end
  endtask
  function automatic logic [DATA_WIDTH-1:0] mrg(input logic [DATA_WIDTH-1:0] o,
      input logic [DATA_WIDTH-1:0] d, input logic [LANES-1:0] l);
    for (int i = 0; i < LANES; i++) begin
      if (!l[i]) o[i*LANE_WIDTH +: LANE_WIDTH] = d[i*LANE_WIDTH +: LANE_WIDTH];
    end
    return o;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [DATA_WIDTH-1:0] d1, d2,
      input logic [LANES-1:0] l1, l2);
    at(2'h0);
    {strobe_n, rnw, addr} <= {2'h0, a};
    at(2'h0);
    {strobe_n, din, lanes} <= {1'h1, d1, l1};
    at(2'h1);
    {din, lanes} <= {d2, l2};
    ref_mem[a] = mrg(ref_mem[a], d1, l1);
    ref_mem[a ^ 6'h1] = mrg(ref_mem[a ^ 6'h1], d2, l2);
  endtask
  task automatic rd(input logic [5:0] a);
    at(2'h0);
    {strobe_n, rnw, addr} <= {2'h1, a};
    at(2'h0);
    strobe_n <= 1'h1;
    at(2'h3);
    #1 cmp({oe, dout}, {1'h1, ref_mem[a]});
    at(2'h0);
    #1 cmp({oe, dout}, {1'h1, ref_mem[a ^ 6'h1]});
    at(2'h0);
    #1 cmp({oe, 36'h0}, 37'h0);
  endtask
  // clocks stopped in mid-burst: pins hold word one
  task automatic rd_stop(input logic [5:0] a);
    at(2'h0);
    {strobe_n, rnw, addr} <= {2'h1, a};
    at(2'h0);
    strobe_n <= 1'h1;
    at(2'h3);
    run <= 1'h0;
    repeat (6) @(posedge clk);
    #1 cmp({oe, dout}, {1'h1, ref_mem[a]});
    @(posedge clk);
    run <= 1'h1;
    at(2'h0);
    #1 cmp({oe, dout}, {1'h1, ref_mem[a ^ 6'h1]});
    at(2'h0);
    #1 cmp({oe, 36'h0}, 37'h0);
  endtask
  // mid-run reset with both output clocks strapped high
  task automatic reset_single();
    @(posedge clk);
    {reset, strap} <= 2'h3;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    #1 cmp({oe, dout}, 37'h0);
    cmp({36'h0, single}, 37'h1);
  endtask
  // single-clock read: word one on k_n, word two on the next k
  task automatic rd1(input logic [5:0] a);
    at(2'h0);
    {strobe_n, rnw, addr} <= {2'h1, a};
    at(2'h0);
    strobe_n <= 1'h1;
    at(2'h2);
    #1 cmp({oe, dout}, {1'h1, ref_mem[a]});
    at(2'h1);
    #1 cmp({oe, dout}, {1'h1, ref_mem[a ^ 6'h1]});
    at(2'h1);
    #1 cmp({oe, 36'h0}, 37'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    {reset, run} <= 2'h1;
    #1 cmp({oe, dout}, 37'h0);
    cmp({36'h0, single}, 37'h0);
    wr(6'h5, 36'h123456789, 36'h987654321, 4'h0, 4'h0);
    rd(6'h5);
    wr(6'h5, 36'hfffffffff, 36'hfffffffff, 4'h6, 4'hf);
    rd(6'h4);
    rd_stop(6'h5);
    reset_single();
    wr(6'h2a, 36'h13579bdf0, 36'h2468ace01, 4'h0, 4'h0);
    rd1(6'h2b);
    at(2'h0);
    {strobe_n, rnw} <= 2'h3;
    repeat (3) at(2'h0);
    #1 cmp({oe, 36'h0}, 37'h0);
    summarize();
  end
endmodule
